// ===== design/mtm_pkg.sv
// package: map, field layouts and codes of the multichannel timer
package mtm_pkg;
	localparam int CH_N = 3;
	localparam int REG_N = 4;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int PIN_N = 8;
	localparam int EXT_N = 4;
	localparam int DIV_W = 6;
	localparam int ACT_W = 4;
	// ****************************************
	// register map: page 0 global, page n+1 channel n
	// ****************************************
	localparam logic [1:0] PAGE_GLB = 2'h0;
	localparam logic [5:0] OFS_START = 6'h00;
	localparam logic [5:0] OFS_SYNC = 6'h04;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_ACT = 6'h08;
	localparam logic [5:0] OFS_IRQEN = 6'h0c;
	localparam logic [5:0] OFS_STAT = 6'h10;
	localparam logic [5:0] OFS_CNT = 6'h14;
	localparam logic [5:0] OFS_GREG = 6'h18;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] GREG_RST = 16'hffff;
	// ****************************************
	// field codes
	// ****************************************
	localparam logic [2:0] CLR_A = 3'h1;
	localparam logic [2:0] CLR_B = 3'h2;
	localparam logic [2:0] CLR_SYNC = 3'h3;
	localparam logic [2:0] CLR_C = 3'h5;
	localparam logic [2:0] CLR_D = 3'h6;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LO = 2'h1;
	localparam logic [1:0] ACT_HI = 2'h2;
	localparam int ACT_INIT = 2;
	localparam int ACT_CAPT = 3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam int PSC_EXT = 2;
	localparam logic [1:0] PSC_DIV1 = 2'h0;
	localparam logic [1:0] PSC_DIV4 = 2'h1;
	localparam logic [1:0] PSC_DIV16 = 2'h2;
	localparam logic [DIV_W-1:0] MSK_DIV4 = 6'h03;
	localparam logic [DIV_W-1:0] MSK_DIV16 = 6'h0f;
	localparam logic [DIV_W-1:0] MSK_DIV64 = 6'h3f;
	localparam logic [1:0] PH_M1 = 2'h0;
	localparam logic [1:0] PH_M2 = 2'h1;
	localparam logic [1:0] PH_M3 = 2'h2;
	localparam int ST_OVF = 4;
	localparam int ST_UDF = 5;
	localparam int ST_DIR = 7;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_PWM1 = 2'h1,
		MODE_PWM2 = 2'h2,
		MODE_PHASE = 2'h3
	} mtm_mode_e;
	typedef struct packed {
		logic [2:0] clr;
		logic [1:0] edge_sel;
		logic [2:0] psc;
	} mtm_ctrl_s;
	typedef struct packed {
		logic [1:0] phase;
		logic buf_b;
		logic buf_a;
		mtm_mode_e mode;
	} mtm_modecfg_s;
endpackage

// ===== design/mtm_timer_top.sv
// three-channel 16-bit timer with sync, buffer, pwm and encoder modes
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
module mtm_timer_top (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [mtm_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// waveform pins: 0A 0B 0C 0D 1A 1B 2A 2B
	input wire logic [mtm_pkg::PIN_N-1:0] i_wave_in,
	output logic [mtm_pkg::PIN_N-1:0] o_wave,
	output logic [mtm_pkg::PIN_N-1:0] o_wave_oe,
	// external clocks a..d
	input wire logic [mtm_pkg::EXT_N-1:0] i_ext_clock
);
	localparam int CH_N = mtm_pkg::CH_N;
	localparam int REG_N = mtm_pkg::REG_N;
	localparam int W = mtm_pkg::CNT_W;

	// ****************************************
	// helpers
	// ****************************************
	function automatic int pin_of(input int c, input int r);
		return (c == 0) ? r : 2 * c + 2 + r;
	endfunction

	function automatic logic has_reg(input int c, input int r);
		return (c == 0) || (r < 2);
	endfunction

	// register index named by a clear selection, -1 when none
	function automatic int clr_reg(input logic [2:0] code);
		case (code)
			mtm_pkg::CLR_A: return 0;
			mtm_pkg::CLR_B: return 1;
			mtm_pkg::CLR_C: return 2;
			mtm_pkg::CLR_D: return 3;
			default: return -1;
		endcase
	endfunction

	function automatic logic act_lvl(input logic [1:0] code, input logic lvl);
		case (code)
			mtm_pkg::ACT_NONE: return lvl;
			mtm_pkg::ACT_LO: return 1'b0;
			mtm_pkg::ACT_HI: return 1'b1;
			default: return ~lvl;
		endcase
	endfunction

	// {up, down} from phase inputs and their previous samples
	function automatic logic [1:0] phase_dec(input logic [1:0] pm, input logic a,
			input logic ap, input logic b, input logic bp);
		logic ar, af, br, bf, up, dn;
		ar = a & ~ap;
		af = ~a & ap;
		br = b & ~bp;
		bf = ~b & bp;
		case (pm)
			mtm_pkg::PH_M1: begin
				up = (a & br) | (~a & bf) | (ar & ~b) | (af & b);
				dn = (a & bf) | (~a & br) | (ar & b) | (af & ~b);
			end
			mtm_pkg::PH_M2: begin
				up = af & b;
				dn = af & ~b;
			end
			mtm_pkg::PH_M3: begin
				up = af & b;
				dn = a & bf;
			end
			default: begin
				up = (a & br) | (~a & bf);
				dn = (a & bf) | (~a & br);
			end
		endcase
		return {up, dn};
	endfunction

	// count enable from prescaler or selected external clock edge
	function automatic logic psc_tick(input mtm_pkg::mtm_ctrl_s ct,
			input logic [mtm_pkg::DIV_W-1:0] div, input logic [mtm_pkg::EXT_N-1:0] ex,
			input logic [mtm_pkg::EXT_N-1:0] exp);
		logic rise, fall, t;
		rise = ex[ct.psc[1:0]] & ~exp[ct.psc[1:0]];
		fall = ~ex[ct.psc[1:0]] & exp[ct.psc[1:0]];
		t = 1'b0;
		if (ct.psc[mtm_pkg::PSC_EXT]) begin
			case (ct.edge_sel)
				mtm_pkg::EDGE_RISE: t = rise;
				mtm_pkg::EDGE_FALL: t = fall;
				default: t = rise | fall;
			endcase
		end else begin
			case (ct.psc[1:0])
				mtm_pkg::PSC_DIV1: t = 1'b1;
				mtm_pkg::PSC_DIV4: t = (div & mtm_pkg::MSK_DIV4) == '0;
				mtm_pkg::PSC_DIV16: t = (div & mtm_pkg::MSK_DIV16) == '0;
				default: t = (div & mtm_pkg::MSK_DIV64) == '0;
			endcase
		end
		return t;
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [CH_N-1:0] start_ff, sync_ff, ovf_ff, udf_ff, dir_ff;
	mtm_pkg::mtm_ctrl_s ctrl_ff [CH_N];
	mtm_pkg::mtm_modecfg_s mode_ff [CH_N];
	logic [REG_N*mtm_pkg::ACT_W-1:0] act_ff [CH_N];
	logic [7:0] irqen_ff [CH_N];
	logic [REG_N-1:0] flag_ff [CH_N];
	logic [W-1:0] cnt_ff [CH_N];
	logic [W-1:0] greg_ff [CH_N][REG_N];
	logic [mtm_pkg::DIV_W-1:0] div_ff;
	logic [mtm_pkg::EXT_N-1:0] ext_prev_ff;
	logic [mtm_pkg::PIN_N-1:0] pin_prev_ff, wave_ff, oe_ff, nxt_wave, nxt_oe;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff, rd_data;
	logic dec_err, wr_go;
	logic [1:0] page;
	logic [5:0] off;
	int wch, gidx;
	logic [CH_N-1:0] tick, up, dn, own_clr, clr, load, phase, stat_wr;
	logic [REG_N-1:0] match [CH_N];
	logic [REG_N-1:0] capt [CH_N];

	assign page = i_paddr[7:6];
	assign off = i_paddr[5:0];
	assign wch = int'(page) - 1;
	assign gidx = int'(off - mtm_pkg::OFS_GREG) >> 2;
	assign wr_go = i_psel & i_penable & pready_ff & i_pwrite & ~dec_err;
	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_wave = wave_ff;
	assign o_wave_oe = oe_ff;

	// ****************************************
	// apb slave
	// ****************************************
	// read mux and address decode, shared by reads and writes
	always_comb begin
		logic [7:0] st;
		st = '0;
		rd_data = '0;
		dec_err = 1'b0;
		if (page == mtm_pkg::PAGE_GLB) begin
			if (off == mtm_pkg::OFS_START) rd_data = 32'(start_ff);
			else if (off == mtm_pkg::OFS_SYNC) rd_data = 32'(sync_ff);
			else dec_err = 1'b1;
		end else begin
			st[REG_N-1:0] = flag_ff[wch];
			st[mtm_pkg::ST_OVF] = ovf_ff[wch];
			st[mtm_pkg::ST_UDF] = udf_ff[wch];
			st[mtm_pkg::ST_DIR] = dir_ff[wch];
			case (off)
				mtm_pkg::OFS_CTRL: rd_data = 32'(ctrl_ff[wch]);
				mtm_pkg::OFS_MODE: rd_data = 32'(mode_ff[wch]);
				mtm_pkg::OFS_ACT: rd_data = 32'(act_ff[wch]);
				mtm_pkg::OFS_IRQEN: rd_data = 32'(irqen_ff[wch]);
				mtm_pkg::OFS_STAT: rd_data = 32'(st);
				mtm_pkg::OFS_CNT: rd_data = 32'(cnt_ff[wch]);
				default: begin
					if (off >= mtm_pkg::OFS_GREG && off[1:0] == 2'h0 && gidx < REG_N &&
							has_reg(wch, gidx))
						rd_data = 32'(greg_ff[wch][gidx]);
					else
						dec_err = 1'b1;
				end
			endcase
		end
	end

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= i_psel & i_penable & ~pready_ff;
			if (i_psel & i_penable & ~pready_ff) begin
				prdata_ff <= i_pwrite ? '0 : rd_data;
				pslverr_ff <= dec_err;
			end
		end
	end

	// ****************************************
	// count enables, matches, captures, clears
	// ****************************************
	always_comb begin
		logic [1:0] ud;
		logic [mtm_pkg::ACT_W-1:0] a;
		logic pwm, inp, inpp;
		int cr, ea;
		ud = '0;
		a = '0;
		pwm = 1'b0;
		inp = 1'b0;
		inpp = 1'b0;
		cr = -1;
		ea = 0;
		for (int c = 0; c < CH_N; c++) begin
			phase[c] = (c > 0) && (mode_ff[c].mode == mtm_pkg::MODE_PHASE);
			ea = (c > 0) ? 2 * (c - 1) : 0;
			ud = phase_dec(mode_ff[c].phase, i_ext_clock[ea], ext_prev_ff[ea],
				i_ext_clock[ea + 1], ext_prev_ff[ea + 1]);
			up[c] = start_ff[c] & phase[c] & ud[1];
			dn[c] = start_ff[c] & phase[c] & ud[0];
			// prescale and edge select bypassed in encoder mode
			tick[c] = phase[c] ? (up[c] | dn[c]) :
				(start_ff[c] & psc_tick(ctrl_ff[c], div_ff, i_ext_clock, ext_prev_ff));
			pwm = mode_ff[c].mode == mtm_pkg::MODE_PWM1 ||
				mode_ff[c].mode == mtm_pkg::MODE_PWM2;
			for (int r = 0; r < REG_N; r++) begin
				a = act_ff[c][r*mtm_pkg::ACT_W +: mtm_pkg::ACT_W];
				inp = i_wave_in[pin_of(c, r)];
				inpp = pin_prev_ff[pin_of(c, r)];
				match[c][r] = has_reg(c, r) && tick[c] && cnt_ff[c] == greg_ff[c][r] &&
					(pwm || !a[mtm_pkg::ACT_CAPT]);
				capt[c][r] = has_reg(c, r) && !pwm && a[mtm_pkg::ACT_CAPT] &&
					((a[1:0] == mtm_pkg::EDGE_RISE) ? (inp & ~inpp) :
					(a[1:0] == mtm_pkg::EDGE_FALL) ? (~inp & inpp) : (inp ^ inpp));
			end
			cr = clr_reg(ctrl_ff[c].clr);
			own_clr[c] = (cr >= 0) && (match[c][cr] || capt[c][cr]);
			load[c] = wr_go && page != mtm_pkg::PAGE_GLB && off == mtm_pkg::OFS_CNT &&
				(c == wch || (sync_ff[c] && sync_ff[wch]));
			stat_wr[c] = wr_go && page != mtm_pkg::PAGE_GLB && off == mtm_pkg::OFS_STAT && wch == c;
		end
		for (int c = 0; c < CH_N; c++) begin
			clr[c] = own_clr[c] || (sync_ff[c] && ctrl_ff[c].clr == mtm_pkg::CLR_SYNC &&
				|(own_clr & sync_ff & ~(CH_N'(1) << c)));
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			start_ff <= '0;
			sync_ff <= '0;
			for (int c = 0; c < CH_N; c++) begin
				ctrl_ff[c] <= '0;
				mode_ff[c] <= '0;
				act_ff[c] <= '0;
				irqen_ff[c] <= '0;
			end
		end else if (wr_go) begin
			if (page == mtm_pkg::PAGE_GLB) begin
				if (off == mtm_pkg::OFS_START) start_ff <= i_pwdata[CH_N-1:0];
				if (off == mtm_pkg::OFS_SYNC) sync_ff <= i_pwdata[CH_N-1:0];
			end else begin
				case (off)
					mtm_pkg::OFS_CTRL: ctrl_ff[wch] <= mtm_pkg::mtm_ctrl_s'(i_pwdata[7:0]);
					mtm_pkg::OFS_MODE: mode_ff[wch] <= mtm_pkg::mtm_modecfg_s'(i_pwdata[5:0]);
					mtm_pkg::OFS_ACT: act_ff[wch] <= i_pwdata[REG_N*mtm_pkg::ACT_W-1:0];
					mtm_pkg::OFS_IRQEN: irqen_ff[wch] <= i_pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// free prescaler and input history for edge detection
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_ff <= '0;
			ext_prev_ff <= '0;
			pin_prev_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
			ext_prev_ff <= i_ext_clock;
			pin_prev_ff <= i_wave_in;
		end
	end

	// ****************************************
	// counters and status
	// ****************************************
	// bus preset beats clear, clear beats counting
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int c = 0; c < CH_N; c++) cnt_ff[c] <= mtm_pkg::CNT_RST;
		end else begin
			for (int c = 0; c < CH_N; c++) begin
				if (load[c]) cnt_ff[c] <= i_pwdata[W-1:0];
				else if (clr[c]) cnt_ff[c] <= mtm_pkg::CNT_RST;
				else if (tick[c]) cnt_ff[c] <= dn[c] ? cnt_ff[c] - 1'b1 : cnt_ff[c] + 1'b1;
			end
		end
	end

	// flags clear by writing zero; a same-cycle event still sets
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ovf_ff <= '0;
			udf_ff <= '0;
			dir_ff <= '1;
			for (int c = 0; c < CH_N; c++) flag_ff[c] <= '0;
		end else begin
			for (int c = 0; c < CH_N; c++) begin
				flag_ff[c] <= (stat_wr[c] ? flag_ff[c] & i_pwdata[REG_N-1:0] : flag_ff[c]) |
					match[c] | capt[c];
				ovf_ff[c] <= (stat_wr[c] ? ovf_ff[c] & i_pwdata[mtm_pkg::ST_OVF] : ovf_ff[c]) |
					(tick[c] & ~dn[c] & cnt_ff[c] == mtm_pkg::CNT_MAX & ~clr[c] & ~load[c]);
				udf_ff[c] <= (stat_wr[c] ? udf_ff[c] & i_pwdata[mtm_pkg::ST_UDF] : udf_ff[c]) |
					(dn[c] & cnt_ff[c] == mtm_pkg::CNT_RST & ~clr[c] & ~load[c]);
				if (tick[c]) dir_ff[c] <= ~dn[c];
			end
		end
	end

	// ****************************************
	// general registers and channel 0 buffering
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int c = 0; c < CH_N; c++)
				for (int r = 0; r < REG_N; r++) greg_ff[c][r] <= mtm_pkg::GREG_RST;
		end else begin
			for (int c = 0; c < CH_N; c++) begin
				for (int r = 0; r < REG_N; r++) begin
					if (wr_go && page != mtm_pkg::PAGE_GLB && off >= mtm_pkg::OFS_GREG &&
							wch == c && gidx == r)
						greg_ff[c][r] <= i_pwdata[W-1:0];
					if (capt[c][r]) greg_ff[c][r] <= cnt_ff[c];
				end
			end
			// later assignments win: buffer moves override plain updates
			for (int r = 0; r < 2; r++) begin
				if (r == 0 ? mode_ff[0].buf_a : mode_ff[0].buf_b) begin
					if (match[0][r]) greg_ff[0][r] <= greg_ff[0][r + 2];
					if (capt[0][r]) greg_ff[0][r + 2] <= greg_ff[0][r];
				end
			end
		end
	end

	// ****************************************
	// waveform pins
	// ****************************************
	always_comb begin
		logic [mtm_pkg::ACT_W-1:0] a, aq;
		logic wa;
		int p, cr;
		a = '0;
		aq = '0;
		wa = 1'b0;
		p = 0;
		cr = -1;
		nxt_wave = wave_ff;
		nxt_oe = oe_ff;
		for (int c = 0; c < CH_N; c++) begin
			cr = clr_reg(ctrl_ff[c].clr);
			wa = wr_go && page != mtm_pkg::PAGE_GLB && off == mtm_pkg::OFS_ACT && wch == c;
			for (int r = 0; r < REG_N; r++) begin
				if (has_reg(c, r)) begin
					p = pin_of(c, r);
					a = act_ff[c][r*mtm_pkg::ACT_W +: mtm_pkg::ACT_W];
					case (mode_ff[c].mode)
						mtm_pkg::MODE_PWM1: begin
							nxt_oe[p] = (r % 2) == 0;
							if ((r % 2) == 0) begin
								aq = act_ff[c][(r+1)*mtm_pkg::ACT_W +: mtm_pkg::ACT_W];
								if (greg_ff[c][r] != greg_ff[c][r + 1]) begin
									if (match[c][r]) nxt_wave[p] = act_lvl(a[1:0], wave_ff[p]);
									if (match[c][r + 1]) nxt_wave[p] = act_lvl(aq[1:0], wave_ff[p]);
								end
							end
						end
						mtm_pkg::MODE_PWM2: begin
							nxt_oe[p] = (r != cr);
							if (match[c][r] && !clr[c]) nxt_wave[p] = act_lvl(a[1:0], wave_ff[p]);
							// simultaneous duty and cycle match: pin holds
							if (clr[c] && !match[c][r]) nxt_wave[p] = a[mtm_pkg::ACT_INIT];
						end
						default: begin
							nxt_oe[p] = !a[mtm_pkg::ACT_CAPT] && a[1:0] != mtm_pkg::ACT_NONE;
							if (match[c][r]) nxt_wave[p] = act_lvl(a[1:0], wave_ff[p]);
						end
					endcase
					// writing the action register presets the initial level
					if (wa) nxt_wave[p] = i_pwdata[r*mtm_pkg::ACT_W + mtm_pkg::ACT_INIT];
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wave_ff <= '0;
			oe_ff <= '0;
		end else begin
			wave_ff <= nxt_wave;
			oe_ff <= nxt_oe;
		end
	end
endmodule

// ===== verif/mtm_enc_model.sv
// two-phase encoder model driving the four external clock pins
`timescale 1ns/100ps
module mtm_enc_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// step requests from the bench, one-cycle pulses
	input wire logic i_up,
	input wire logic i_dn,
	input wire logic i_pair,
	// external clock levels a..d
	output logic [3:0] o_ext
);
	logic [1:0] pos_ff [2];

	// quadrature position per pin pair; one step is one edge on one phase
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pos_ff[0] <= 2'h0;
			pos_ff[1] <= 2'h0;
		end else if (i_up || i_dn) begin
			pos_ff[i_pair] <= i_up ? pos_ff[i_pair] + 2'h1 : pos_ff[i_pair] - 2'h1;
		end
	end

	// gray order ab = 00,10,11,01: phase a leads phase b when stepping up
	assign o_ext = {pos_ff[1][1], ^pos_ff[1], pos_ff[0][1], ^pos_ff[0]};
endmodule

// ===== verif/mtm_timer_checker.sv
// concurrent checks on the timer's apb and pin ports
`timescale 1ns/100ps
module mtm_timer_checker (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [mtm_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// pins
	input wire logic [mtm_pkg::PIN_N-1:0] o_wave,
	input wire logic [mtm_pkg::PIN_N-1:0] o_wave_oe
);
	logic wr_done;
	logic [1:0] mode_ff [3];
	logic [2:0] clr2_ff;
	logic [1:0] age_ff;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	assign wr_done = i_psel && i_penable && o_pready && i_pwrite && (i_paddr[7:6] != 2'h0);

	// shadow of the mode fields, so pin checks know the configuration
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_ff <= '{2'h0, 2'h0, 2'h0};
		end else if (wr_done && i_paddr[5:0] == mtm_pkg::OFS_MODE) begin
			mode_ff[i_paddr[7:6] - 2'h1] <= i_pwdata[1:0];
		end
	end

	// shadow of channel 2 clear select
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			clr2_ff <= 3'h0;
		end else if (wr_done && i_paddr == 8'hc0) begin
			clr2_ff <= i_pwdata[7:5];
		end
	end

	// cycles since last channel-page write; pins lag config by a register stage
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			age_ff <= 2'h0;
		end else if (wr_done) begin
			age_ff <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	a_ready_one_wait: assert property ($rose(i_psel && i_penable) |=> o_pready)
		else $error("ready missing one cycle after access");
	a_ready_single: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	a_reset_quiet: assert property ($rose(i_nrst) |-> o_wave == 8'h00 && o_wave_oe == 8'h00)
		else $error("pins active right after reset");
	a_error_with_ready: assert property ($rose(o_pslverr) |-> o_pready)
		else $error("error raised without ready");
	a_no_buf_regs: assert property (o_pready && i_paddr[7:6] > 2'h1 && i_paddr[5:0] == 6'h20 |-> o_pslverr)
		else $error("register c accepted outside channel 0");
	a_count_mapped: assert property (o_pready && i_paddr[7:6] != 2'h0 && i_paddr[5:0] == mtm_pkg::OFS_CNT
		|-> !o_pslverr)
		else $error("counter access refused");
	a_pwm1_bd_idle: assert property (age_ff == 2'h3 && mode_ff[0] == mtm_pkg::MODE_PWM1
		|-> !o_wave_oe[1] && !o_wave_oe[3])
		else $error("pwm1 drives a b or d pin");
	a_pwm2_cycle_idle: assert property (age_ff == 2'h3 && mode_ff[2] == mtm_pkg::MODE_PWM2
		&& clr2_ff == mtm_pkg::CLR_A |-> !o_wave_oe[6])
		else $error("pwm2 cycle pin is driven");
endmodule

// ===== verif/multichannel_timer_modes_test.sv
// self-checking bench for the multichannel timer
`timescale 1ns/100ps
module multichannel_timer_modes_test;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} mtm_row_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, c0;
	logic pready, pslverr, err;
	logic up = 1'b0;
	logic dn = 1'b0;
	logic pair = 1'b0;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] wave, wave_oe;
	logic [3:0] ext;
	int bad_count = 0;
	int n_compared = 0;
	int hi;
	mtm_row_s rows [7];

	always #10 clk = ~clk;

	mtm_timer_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_wave_in(pin_in), .o_wave(wave),
		.o_wave_oe(wave_oe), .i_ext_clock(ext));
	mtm_enc_model u_enc (.i_clk(clk), .i_nrst(nrst), .i_up(up), .i_dn(dn), .i_pair(pair),
		.o_ext(ext));

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		xfer(a, 1'b0, 32'h0);
		chk(rd & m, exp);
	endtask

	// high cycles of one pin over a whole number of periods
	task automatic count_hi(input int b, input int cycles);
		hi = 0;
		repeat (cycles) begin
			@(posedge clk);
			hi += (wave[b] === 1'b1) ? 1 : 0;
		end
	endtask

	// encoder steps with idle gaps so each edge is seen alone
	task automatic enc(input logic u, input logic p, input int n);
		pair <= p;
		repeat (n) begin
			@(posedge clk);
			up <= u;
			dn <= ~u;
			@(posedge clk);
			up <= 1'b0;
			dn <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		give_verdict();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rows[0] = '{8'h54, 32'habcd, 32'habcd, 1'b0};
		rows[1] = '{8'h58, 32'h12345, 32'h2345, 1'b0};
		rows[2] = '{8'h64, 32'h55aa, 32'h55aa, 1'b0};
		rows[3] = '{8'ha0, 32'h1, 32'h0, 1'b1};
		rows[4] = '{8'he4, 32'h1, 32'h0, 1'b1};
		rows[5] = '{8'h3c, 32'h1, 32'h0, 1'b1};
		rows[6] = '{8'h04, 32'hff, 32'h7, 1'b0};
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({24'h0, wave_oe}, 32'h0);
		rdx(8'h5c, 32'hffff, 32'hffffffff);
		rdx(8'h90, 32'h80, 32'hff);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk({31'h0, err}, {31'h0, rows[i].e});
			xfer(rows[i].a, 1'b0, 32'h0);
			chk(rd, rows[i].x);
		end
		// preset through channel 1 reaches channel 0 only
		wr(8'h04, 32'h3);
		wr(8'h94, 32'h3);
		rdx(8'h54, 32'h3, 32'hffff);
		rdx(8'hd4, 32'h0, 32'hffff);
		// pwm1 on channel 0, period on b, a reloaded from c
		wr(8'h40, 32'h40);
		wr(8'h44, 32'h05);
		wr(8'h58, 32'h4);
		wr(8'h5c, 32'h9);
		wr(8'h60, 32'h2);
		wr(8'h48, 32'h16);
		repeat (3) @(posedge clk);
		chk({31'h0, wave[0]}, 32'h1);
		wr(8'h80, 32'h60);
		wr(8'h84, 32'h0);
		wr(8'h00, 32'h3);
		repeat (30) @(posedge clk);
		count_hi(0, 100);
		chk(32'(hi), 32'd70);
		wr(8'h00, 32'h0);
		rdx(8'h58, 32'h2, 32'hffff);
		xfer(8'h54, 1'b0, 32'h0);
		c0 = rd;
		rdx(8'h94, c0, 32'hffffffff);
		chk({31'h0, c0 < 32'ha}, 32'h1);
		// pwm2 on channel 2, a is the cycle register
		wr(8'h04, 32'h0);
		wr(8'hd4, 32'h0);
		wr(8'hc0, 32'h20);
		wr(8'hc4, 32'h02);
		wr(8'hd8, 32'h7);
		wr(8'hdc, 32'h2);
		wr(8'hc8, 32'h20);
		wr(8'h00, 32'h4);
		repeat (20) @(posedge clk);
		count_hi(7, 80);
		chk(32'(hi), 32'd50);
		chk({30'h0, wave_oe[7:6]}, 32'h2);
		// land the equal value while the duty pin is high, before the cycle match
		@(posedge clk iff wave[7] === 1'b0);
		wr(8'hdc, 32'h7);
		repeat (20) @(posedge clk);
		count_hi(7, 40);
		chk(32'(hi), 32'd40);
		wr(8'h00, 32'h0);
		// encoder on channels 1 and 2, prescale and edge set on channel 1 but ignored
		wr(8'h80, 32'h0b);
		wr(8'h84, 32'h03);
		wr(8'hc0, 32'h00);
		wr(8'hc4, 32'h03);
		wr(8'h94, 32'hfffe);
		wr(8'hd4, 32'h10);
		wr(8'h00, 32'h6);
		enc(1'b1, 1'b0, 4);
		rdx(8'h94, 32'h2, 32'hffff);
		rdx(8'h90, 32'h90, 32'hb0);
		enc(1'b0, 1'b0, 4);
		rdx(8'h94, 32'hfffe, 32'hffff);
		rdx(8'h90, 32'h30, 32'hb0);
		rdx(8'hd4, 32'h10, 32'hffff);
		enc(1'b1, 1'b1, 2);
		rdx(8'hd4, 32'h12, 32'hffff);
		// buffered capture on channel 0, counter stopped so the value is known
		wr(8'h54, 32'h1234);
		wr(8'h44, 32'h04);
		wr(8'h48, 32'h08);
		wr(8'h58, 32'haaa);
		pin_in <= 8'h01;
		@(posedge clk);
		pin_in <= 8'h00;
		rdx(8'h58, 32'h1234, 32'hffff);
		rdx(8'h60, 32'haaa, 32'hffff);
		// reset in mid-run clears pins, counters and flags
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({16'h0, wave_oe, wave}, 32'h0);
		rdx(8'h94, 32'h0, 32'hffff);
		rdx(8'h90, 32'h80, 32'hff);
		give_verdict();
	end
endmodule

bind mtm_timer_top mtm_timer_checker u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_wave(o_wave),
	.o_wave_oe(o_wave_oe));
